//--- bench/testbench.sv
// Self-checking bench for the receive statistics control block
`timescale 1ns/1ps
`default_nettype none
`include "rx_stats_cfg.svh"
module testbench;
    import rx_stats_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [`ADR_W-1:0] wbAdr = '0;
    logic [3:0] wbSel = 4'h0;
    logic [`DATA_W-1:0] wbDatWr = '0;
    logic [`DATA_W-1:0] wbDatRd;
    logic wbAck;
    logic [`INC_W-1:0] inc = '0;
    logic incStrobe = 1'b0;
    logic frameErr = 1'b0;
    logic irq;
    int failCount = 0;
    int comparisons = 0;
    count_t expCount = '0;
    count_t frozen = '0;
    logic [`DATA_W-1:0] rd;

    // Free-running 25 MHz clock
    always #20 clk = ~clk;

    rx_statistics_control_counters dut_u (
        .clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatWr(wbDatWr), .wbDatRd(wbDatRd),
        .wbAck(wbAck), .rxGoodByteIncrement(inc),
        .rxGoodByteIncrementStrobe(incStrobe), .rxFrameErrored(frameErr), .irq(irq)
    );

    // Single place that ends the run
    task automatic stopTest;
        $display("comparisons %0d, mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stopTest

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Classic Wishbone cycle; request held until ack is sampled, then one idle cycle
    task automatic busCycle(input logic we, input logic [11:0] idx, input logic [31:0] dat,
            input logic [3:0] sel, output logic [31:0] data);
        int waits;
        waits = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'b00};
        wbSel <= sel;
        wbDatWr <= dat;
        @(posedge clk);
        while (wbAck !== 1'b1 && waits < 20) begin
            @(posedge clk);
            waits++;
        end
        if (wbAck !== 1'b1) begin
            failCount++;
            $display("unexpected missing ack at %0t: got %h expected %h", $time, wbAck, 1'b1);
            stopTest();
        end
        data = wbDatRd;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clk);
    endtask : busCycle

    task automatic wr(input logic [11:0] idx, input logic [31:0] dat);
        busCycle(1'b1, idx, dat, 4'hf, rd);
    endtask : wr

    task automatic rdChk(input logic [11:0] idx, input logic [31:0] exp);
        busCycle(1'b0, idx, 32'h0, 4'hf, rd);
        check(rd, exp);
    endtask : rdChk

    task automatic chkCount(input count_t c);
        rdChk(`RX_BYTES_LO_IDX, c[31:0]);
        rdChk(`RX_BYTES_HI_IDX, c[63:32]);
    endtask : chkCount

    // expected count after one receive cycle; wraps like the hardware
    function automatic count_t nextCount(input count_t c, input logic s, input logic e,
            input logic [15:0] v);
        return (s && !e) ? c + 64'(v) : c;
    endfunction : nextCount

    // Receive-path stimulus; full mode adds the largest increment every cycle
    task automatic pump(input int n, input bit full);
        logic s;
        logic e;
        logic [15:0] v;
        repeat (n) begin
            s = full || $urandom_range(0, 3) != 0;
            e = !full && $urandom_range(0, 3) == 0;
            v = (full || $urandom_range(0, 7) == 0) ? 16'hffff : 16'($urandom);
            incStrobe <= s;
            frameErr <= e;
            inc <= v;
            @(posedge clk);
            expCount = nextCount(expCount, s, e, v);
        end
        incStrobe <= 1'b0;
        frameErr <= 1'b0;
    endtask : pump

    initial begin
        void'($urandom(32'h9b95));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdChk(`RX_CTRL_IDX, 32'h0);
        rdChk(`RX_STATE_IDX, 32'h0);
        chkCount(64'h0);
        rdChk(`RX_IRQ_MASK_IDX, 32'h0);
        // random traffic, then a carry into the high word
        pump(300, 1'b0);
        chkCount(expCount);
        pump(65537, 1'b1);
        chkCount(expCount);
        // shadow freezes the view while counting goes on
        wr(`RX_CTRL_IDX, 32'h4);
        frozen = expCount;
        rdChk(`RX_CTRL_IDX, 32'h4);
        rdChk(`RX_STATE_IDX, 32'h2);
        pump(80, 1'b0);
        chkCount(frozen);
        rdChk(`RX_CTRL_IDX, 32'h4);
        wr(`RX_CTRL_IDX, 32'h0);
        rdChk(`RX_STATE_IDX, 32'h0);
        chkCount(expCount);
        wr(`RX_CTRL_IDX, 32'hfffffff8);
        rdChk(`RX_CTRL_IDX, 32'h0);
        pump(40, 1'b0);
        chkCount(expCount);
        wr(`RX_STATE_IDX, 32'hffffffff);
        rdChk(`RX_STATE_IDX, 32'h0);
        // parity clear self-clears, flag stays low
        wr(`RX_CTRL_IDX, 32'h2);
        rdChk(`RX_CTRL_IDX, 32'h0);
        rdChk(`RX_STATE_IDX, 32'h0);
        // byte lane 0 disabled, so the write must not land
        busCycle(1'b1, `RX_CTRL_IDX, 32'h4, 4'he, rd);
        rdChk(`RX_CTRL_IDX, 32'h0);
        // reset-all clears the count and self-clears
        wr(`RX_CTRL_IDX, 32'h1);
        expCount = '0;
        rdChk(`RX_CTRL_IDX, 32'h0);
        chkCount(64'h0);
        pump(60, 1'b0);
        // reset-all with shadow set shows a zero snapshot
        wr(`RX_CTRL_IDX, 32'h5);
        expCount = '0;
        pump(30, 1'b0);
        chkCount(64'h0);
        rdChk(`RX_STATE_IDX, 32'h2);
        wr(`RX_CTRL_IDX, 32'h0);
        chkCount(expCount);
        // interrupt mask, clear and an unmapped word
        wr(`RX_IRQ_MASK_IDX, 32'h3);
        rdChk(`RX_IRQ_MASK_IDX, 32'h3);
        wr(`RX_IRQ_STATUS_IDX, 32'h3);
        rdChk(`RX_IRQ_STATUS_IDX, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(`RX_IRQ_MASK_IDX, 32'h1);
        rdChk(12'h123, 32'h0);
        // second reset in mid-run, with pause and mask left set
        wr(`RX_CTRL_IDX, 32'h4);
        pump(20, 1'b0);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chkCount(64'h0);
        rdChk(`RX_IRQ_MASK_IDX, 32'h0);
        rdChk(`RX_CTRL_IDX, 32'h0);
        rdChk(`RX_STATE_IDX, 32'h0);
        stopTest();
    end

    // Watchdog; a clean run needs about 66000 cycles
    initial begin
        repeat (90000) @(posedge clk);
        failCount++;
        $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        stopTest();
    end
endmodule : testbench
`default_nettype wire

//--- hdl/rx_byte_counter.sv
// Live 64-bit good byte counter with per-word parity check
`timescale 1ns/1ps
`default_nettype none
`include "rx_stats_cfg.svh"
module rx_byte_counter
    import rx_stats_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    stat_if.counter cnt
);
    counter_state_s st;
    counter_state_s next_st;
    logic [`CNT_W:0] sum;

    // Count, wrap and parity bookkeeping
    always_comb begin
        next_st = st;
        sum = {1'b0, st.count} + {{(`CNT_W-`INC_W+1){1'b0}}, cnt.inc};
        next_st.wrap = 1'b0;
        // Stored parity disagreeing with the word flags an upset
        next_st.parityFault = (^st.count[31:0] != st.parity[0]) |
            (^st.count[63:32] != st.parity[1]);
        if (cnt.clear) begin
            next_st.count = `COUNT_RESET;
        end else if (cnt.incValid) begin
            // Wraps modulo two to the 64th
            next_st.count = sum[`CNT_W-1:0];
            next_st.wrap = sum[`CNT_W];
        end
        next_st.parity = {^next_st.count[63:32], ^next_st.count[31:0]};
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cnt.live = st.count;
    assign cnt.parityFault = st.parityFault;
    assign cnt.wrap = st.wrap;
endmodule : rx_byte_counter
`default_nettype wire

//--- hdl/rx_snapshot.sv
// Frozen copy of the counter shown while software pauses the view
`timescale 1ns/1ps
`default_nettype none
`include "rx_stats_cfg.svh"
module rx_snapshot
    import rx_stats_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    stat_if.snap snp
);
    snapshot_state_s st;
    snapshot_state_s next_st;

    // Clear beats capture so a reset during pause reads zero
    always_comb begin
        next_st = st;
        if (snp.clear) begin
            next_st.held = `COUNT_RESET;
        end else if (snp.capture) begin
            next_st.held = snp.live;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign snp.held = st.held;
endmodule : rx_snapshot
`default_nettype wire

//--- hdl/rx_statistics_control_counters.sv
// Receive statistics control, status and good byte counter behind Wishbone
// Function
// - While the shadow bit is one, reads show the values captured when it was set.
// - The shadow bit stays set until software writes zero, then reads track live.
// - Writing one to parity-clear clears the parity flag and the bit reads zero.
// - Writing one to reset-all clears all statistics at once and reads back zero.
// - Control bits 31 to 3 are reserved and have no effect.
// - The paused status bit follows the shadow bit.
// - The parity status bit sets on any counter parity error until cleared.
// - Status upper bits read zero and writes to status do nothing.
// - Only bytes of frames without FCS, size or length errors are counted.
// - Each cycle the strobe is high the 16-bit increment is added.
// - The 64-bit count reads as a low word and a high word.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "rx_stats_cfg.svh"
module rx_statistics_control_counters
    import rx_stats_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [`ADR_W-1:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [`DATA_W-1:0] wbDatWr,
    output logic [`DATA_W-1:0] wbDatRd,
    output logic wbAck,
    input wire logic [`INC_W-1:0] rxGoodByteIncrement,
    input wire logic rxGoodByteIncrementStrobe,
    input wire logic rxFrameErrored,
    output logic irq
);
    top_state_s st;
    top_state_s next_st;

    stat_if link ();

    logic [11:0] idx;
    logic req;
    logic wr;
    logic rd;
    logic ctrlWr;
    logic irqStatusWr;
    logic irqMaskWr;
    logic resetAllPulse;
    logic parityClearPulse;
    count_t readable;
    logic [`IRQ_W-1:0] events;
    logic [`DATA_W-1:0] rdMux;

    // Live counter and its frozen copy
    rx_byte_counter counter (
        .clk(clk),
        .rst(rst),
        .cnt(link.counter)
    );

    rx_snapshot snapshot (
        .clk(clk),
        .rst(rst),
        .snp(link.snap)
    );

    // Bus decode; a new request only when no ack is pending
    assign idx = wbAdr[`ADR_W-1:2];
    assign req = wbCyc & wbStb & ~st.ack;
    assign wr = req & wbWe;
    assign rd = req & ~wbWe;
    assign ctrlWr = wr & (idx == `RX_CTRL_IDX) & wbSel[0];
    assign irqStatusWr = wr & (idx == `RX_IRQ_STATUS_IDX) & wbSel[0];
    assign irqMaskWr = wr & (idx == `RX_IRQ_MASK_IDX) & wbSel[0];

    assign resetAllPulse = ctrlWr & wbDatWr[`CTRL_RESET_BIT];
    assign parityClearPulse = ctrlWr & wbDatWr[`CTRL_PCLR_BIT];

    // errored frames never reach the counter
    assign link.inc = rxGoodByteIncrement;
    assign link.incValid = rxGoodByteIncrementStrobe & ~rxFrameErrored;
    assign link.clear = resetAllPulse;
    // capture only on the zero-to-one edge of the shadow bit
    assign link.capture = ctrlWr & wbDatWr[`CTRL_SHADOW_BIT] & ~st.shadow;

    assign readable = st.shadow ? link.held : link.live;

    // Interrupt sources
    assign events[`IRQ_PARERR_BIT] = link.parityFault;
    assign events[`IRQ_WRAP_BIT] = link.wrap;

    // Read data selection; unmapped words read zero
    always_comb begin
        rdMux = '0;
        case (idx)
            `RX_CTRL_IDX: begin
                // self-clearing and reserved bits read zero
                rdMux[`CTRL_SHADOW_BIT] = st.shadow;
            end
            `RX_STATE_IDX: begin
                rdMux[`STATE_PAUSED_BIT] = st.shadow;
                rdMux[`STATE_PARERR_BIT] = st.parityErr;
            end
            `RX_IRQ_STATUS_IDX: begin
                rdMux[`IRQ_W-1:0] = st.irqStatus;
            end
            `RX_IRQ_MASK_IDX: begin
                rdMux[`IRQ_W-1:0] = st.irqMask;
            end
            // low and high words of the 64-bit count
            `RX_BYTES_LO_IDX: begin
                rdMux = readable[31:0];
            end
            `RX_BYTES_HI_IDX: begin
                rdMux = readable[63:32];
            end
            default: begin
                rdMux = '0;
            end
        endcase
    end

    // Next state of the control and bus logic
    always_comb begin
        next_st = st;
        // Ack lasts one cycle; every request is answered, mapped or not
        next_st.ack = req;
        next_st.rdData = rd ? rdMux : '0;
        // shadow bit changes only by a control write
        if (ctrlWr) begin
            next_st.shadow = wbDatWr[`CTRL_SHADOW_BIT];
        end
        // sticky parity flag; a fault in the clear cycle wins
        next_st.parityErr = (st.parityErr & ~parityClearPulse) | link.parityFault;
        // Write-one-to-clear, a new event wins over the clear
        next_st.irqStatus = (st.irqStatus & ~(irqStatusWr ? wbDatWr[`IRQ_W-1:0] : '0))
            | events;
        if (irqMaskWr) begin
            next_st.irqMask = wbDatWr[`IRQ_W-1:0];
        end
        next_st.irq = |(next_st.irqStatus & next_st.irqMask);
    end

    // state register, everything to zero at reset
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.irqMask <= `IRQ_MASK_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign wbAck = st.ack;
    assign wbDatRd = st.rdData;
    assign irq = st.irq;

    // frozen view; a control write may release it or clear it by reset-all
    frozen_view_a: assert property (@(posedge clk) disable iff (rst)
        st.shadow && !ctrlWr |=> $stable(link.held)
        && readable == $past(link.held))
        else $error("paused view changed");

    shadow_hold_a: assert property (@(posedge clk) disable iff (rst)
        st.shadow && !ctrlWr |=> st.shadow)
        else $error("shadow bit dropped without a write");

    release_live_a: assert property (@(posedge clk) disable iff (rst)
        ctrlWr && !wbDatWr[`CTRL_SHADOW_BIT] |=> !st.shadow ##0 readable == link.live)
        else $error("view not live after release");

    parity_clear_a: assert property (@(posedge clk) disable iff (rst)
        parityClearPulse && !link.parityFault |=> !st.parityErr)
        else $error("parity flag not cleared");

    reset_all_a: assert property (@(posedge clk) disable iff (rst)
        resetAllPulse |=> link.live == '0 && link.held == '0)
        else $error("counters not cleared by reset-all");

    // control reads back only the shadow bit
    ctrl_reserved_a: assert property (@(posedge clk) disable iff (rst)
        rd && idx == `RX_CTRL_IDX |=> wbAck && wbDatRd[31:3] == '0
        && wbDatRd[1:0] == 2'h0)
        else $error("control reserved or self-clearing bits read nonzero");

    paused_bit_a: assert property (@(posedge clk) disable iff (rst)
        rd && idx == `RX_STATE_IDX |=> wbDatRd[`STATE_PAUSED_BIT] == $past(st.shadow))
        else $error("paused bit disagrees with shadow");

    parity_set_a: assert property (@(posedge clk) disable iff (rst)
        link.parityFault |=> st.parityErr)
        else $error("parity fault not flagged");

    state_reserved_a: assert property (@(posedge clk) disable iff (rst)
        rd && idx == `RX_STATE_IDX |=> wbDatRd[31:2] == '0)
        else $error("status reserved bits nonzero");

    // errored frames leave the count alone
    errored_frame_a: assert property (@(posedge clk) disable iff (rst)
        rxFrameErrored && !resetAllPulse |=> $stable(link.live))
        else $error("errored frame counted");

    increment_add_a: assert property (@(posedge clk) disable iff (rst)
        rxGoodByteIncrementStrobe && !rxFrameErrored && !resetAllPulse
        |=> link.live == $past(link.live) + $past(link.inc))
        else $error("increment not added");

    high_word_a: assert property (@(posedge clk) disable iff (rst)
        rd && idx == `RX_BYTES_HI_IDX |=> wbDatRd == $past(readable[63:32]))
        else $error("high word mismatch");

    low_word_a: assert property (@(posedge clk) disable iff (rst)
        rd && idx == `RX_BYTES_LO_IDX |=> wbDatRd == $past(readable[31:0]))
        else $error("low word mismatch");

    reset_clean_a: assert property (@(posedge clk)
        $fell(rst) |-> link.live == '0 && link.held == '0 && !st.parityErr && !st.shadow
        && !irq && !wbAck && st.irqMask == '0)
        else $error("state not cleared by reset");

    // Ack is a single-cycle pulse
    ack_pulse_a: assert property (@(posedge clk) disable iff (rst)
        wbAck |=> !wbAck)
        else $error("ack longer than one cycle");

    // Interrupt equals masked status in the same cycle
    irq_level_a: assert property (@(posedge clk) disable iff (rst)
        ##1 irq == |(st.irqStatus & st.irqMask))
        else $error("irq disagrees with masked status");

    // a control write with only reserved bits changes nothing
    ctrl_ignore_a: assert property (@(posedge clk) disable iff (rst)
        ctrlWr && wbDatWr[2:0] == {st.shadow, 2'h0} |=> $stable(st.shadow)
        && $stable(st.parityErr) || $past(link.parityFault))
        else $error("reserved control bits had an effect");

    // writes to status have no effect on the flag
    state_write_a: assert property (@(posedge clk) disable iff (rst)
        wr && idx == `RX_STATE_IDX && !link.parityFault |=> st.parityErr == $past(st.parityErr))
        else $error("status write changed the flag");

    // snapshot takes the live count at the pause edge
    capture_value_a: assert property (@(posedge clk) disable iff (rst)
        link.capture && !link.clear |=> link.held == $past(link.live))
        else $error("snapshot missed the live count");

    // counting goes on behind a paused view
    paused_count_a: assert property (@(posedge clk) disable iff (rst)
        st.shadow && link.incValid && !link.clear
        |=> link.live == $past(link.live) + $past(link.inc))
        else $error("counter stalled while paused");

    // a control write with the shadow bit set pauses the view
    shadow_set_a: assert property (@(posedge clk) disable iff (rst)
        ctrlWr && wbDatWr[`CTRL_SHADOW_BIT] |=> st.shadow)
        else $error("shadow bit not set by write");

    // byte lane 0 off leaves the control bits alone
    lane_gate_a: assert property (@(posedge clk) disable iff (rst)
        wr && idx == `RX_CTRL_IDX && !wbSel[0] |=> $stable(st.shadow))
        else $error("control write without lane 0 landed");

    // unpaused reads follow the live count
    live_read_a: assert property (@(posedge clk) disable iff (rst)
        rd && idx == `RX_BYTES_LO_IDX && !st.shadow |=> wbDatRd == $past(link.live[31:0]))
        else $error("unpaused read not live");

    // reset-all with the shadow bit set shows a zero snapshot
    reset_paused_a: assert property (@(posedge clk) disable iff (rst)
        resetAllPulse && wbDatWr[`CTRL_SHADOW_BIT] |=> st.shadow && readable == '0)
        else $error("paused view not cleared by reset-all");

    // reset-all is a single pulse, the bit never sticks
    reset_once_a: assert property (@(posedge clk) disable iff (rst)
        resetAllPulse |=> !resetAllPulse)
        else $error("reset-all lasted more than one cycle");

    // the status read shows the sticky parity flag
    parity_read_a: assert property (@(posedge clk) disable iff (rst)
        rd && idx == `RX_STATE_IDX |=> wbDatRd[`STATE_PARERR_BIT] == $past(st.parityErr))
        else $error("parity bit read wrong");

    // flag holds without a clear request
    parity_hold_a: assert property (@(posedge clk) disable iff (rst)
        st.parityErr && !parityClearPulse |=> st.parityErr)
        else $error("parity flag dropped by itself");

    count_hold_a: assert property (@(posedge clk) disable iff (rst)
        !link.incValid && !link.clear |=> $stable(link.live))
        else $error("counter moved without a strobe");

    // carry out of bit 63 leaves only the remainder
    wrap_mod_a: assert property (@(posedge clk) disable iff (rst)
        link.wrap |-> link.live < {{(`CNT_W-`INC_W){1'b0}}, {`INC_W{1'b1}}})
        else $error("counter did not wrap");

    // Every request is answered at the next edge
    ack_answer_a: assert property (@(posedge clk) disable iff (rst)
        req |=> wbAck)
        else $error("request not acknowledged");

    // No answer without a request
    ack_cause_a: assert property (@(posedge clk) disable iff (rst)
        !req |=> !wbAck)
        else $error("ack without a request");

    // Read data is zero outside the ack cycle
    rd_idle_a: assert property (@(posedge clk) disable iff (rst)
        !wbAck |-> wbDatRd == '0)
        else $error("read data outside ack");

    // Write-one-to-clear drops the written interrupt bits
    irq_clear_a: assert property (@(posedge clk) disable iff (rst)
        irqStatusWr && events == '0
        |=> (st.irqStatus & $past(wbDatWr[`IRQ_W-1:0])) == '0)
        else $error("interrupt status not cleared");

    // A new event sets its status bit
    irq_event_a: assert property (@(posedge clk) disable iff (rst)
        events != '0 |=> (st.irqStatus & $past(events)) == $past(events))
        else $error("interrupt event lost");

    // Mask write lands
    irq_mask_a: assert property (@(posedge clk) disable iff (rst)
        irqMaskWr |=> st.irqMask == $past(wbDatWr[`IRQ_W-1:0]))
        else $error("interrupt mask not written");
endmodule : rx_statistics_control_counters
`default_nettype wire

//--- hdl/rx_stats_cfg.svh
// Register map, field positions and sizes of the receive statistics block
`ifndef RX_STATS_CFG_SVH
`define RX_STATS_CFG_SVH

// Word indices; byte address is four times the index
`define RX_CTRL_IDX 12'h945
`define RX_STATE_IDX 12'h946
`define RX_IRQ_STATUS_IDX 12'h950
`define RX_IRQ_MASK_IDX 12'h951
`define RX_BYTES_LO_IDX 12'h960
`define RX_BYTES_HI_IDX 12'h961

// Bus and counter widths
`define ADR_W 14
`define DATA_W 32
`define CNT_W 64
`define INC_W 16
`define IRQ_W 2

// Control, state and interrupt fields
`define CTRL_RESET_BIT 0
`define CTRL_PCLR_BIT 1
`define CTRL_SHADOW_BIT 2
`define STATE_PARERR_BIT 0
`define STATE_PAUSED_BIT 1
`define IRQ_PARERR_BIT 0
`define IRQ_WRAP_BIT 1

// Reset values
`define IRQ_MASK_RESET 2'h0
`define COUNT_RESET 64'h0

`endif

//--- hdl/rx_stats_pkg.sv
// Types shared by the receive statistics modules
package rx_stats_pkg;
`include "rx_stats_cfg.svh"

    typedef logic [`CNT_W-1:0] count_t;

    typedef struct packed {
        count_t count;
        logic [1:0] parity;
        logic parityFault;
        logic wrap;
    } counter_state_s;

    typedef struct packed {
        count_t held;
    } snapshot_state_s;

    typedef struct packed {
        logic shadow;
        logic parityErr;
        logic [`IRQ_W-1:0] irqStatus;
        logic [`IRQ_W-1:0] irqMask;
        logic ack;
        logic [`DATA_W-1:0] rdData;
        logic irq;
    } top_state_s;
endpackage : rx_stats_pkg

//--- hdl/stat_if.sv
// Link between the control logic, the live counter and the snapshot
`timescale 1ns/1ps
`default_nettype none
`include "rx_stats_cfg.svh"
interface stat_if;
    import rx_stats_pkg::*;
    logic clear;
    logic [`INC_W-1:0] inc;
    logic incValid;
    logic capture;
    count_t live;
    count_t held;
    logic parityFault;
    logic wrap;

    modport counter (input clear, input inc, input incValid,
        output live, output parityFault, output wrap);
    modport snap (input clear, input capture, input live, output held);
    modport ctl (output clear, output inc, output incValid, output capture,
        input live, input held, input parityFault, input wrap);
endinterface : stat_if
`default_nettype wire
